// ### design/eepc_defines.vh
`ifndef EEPC_DEFINES_VH
`define EEPC_DEFINES_VH
// ============================================================
// i/o addresses (data space adds the offset below)
`define EEPC_IO_CTRL        6'h1C
`define EEPC_IO_DATA        6'h1D
`define EEPC_IO_ADDR_LO     6'h1E
`define EEPC_IO_ADDR_HI     6'h1F
`define EEPC_BIT_IO_LAST    6'h1F
`define EEPC_IO_LAST        8'h3F
`define EEPC_DS_OFFSET      8'h20
// ============================================================
// control register fields
`define EEPC_CR_READ        3'h0
`define EEPC_CR_PROG        3'h1
`define EEPC_CR_ARM         3'h2
`define EEPC_CR_RIE         3'h3
`define EEPC_CR_MODE_LO     3'h4
`define EEPC_CR_MODE_HI     3'h5
// ============================================================
// mode encodings
`define EEPC_MODE_ATOMIC    2'h0
`define EEPC_MODE_ERASE     2'h1
`define EEPC_MODE_WRITE     2'h2
`define EEPC_MODE_RSVD      2'h3
// ============================================================
// timing
`define EEPC_ARM_CYCLES     3'h4
// programming lengths in oscillator ticks: 3.4 ms and 1.8 ms at an 8 MHz tick
`define EEPC_ATOMIC_TICKS   16'h6A40
`define EEPC_SPLIT_TICKS    16'h3840
`define EEPC_CR_RESET       8'h00
`define EEPC_DR_RESET       8'h00
`endif

// ### design/eepc_prog_timer.v
`timescale 1ns/1ns
`include "eepc_defines.vh"
// ============================================================
// programming timer, counts oscillator ticks sampled in the cpu domain
module eepc_prog_timer (
    input  wire        i_clk,
    input  wire        i_start,
    input  wire        i_long,
    input  wire        i_osc_tick,
    output wire        o_busy,
    output wire        o_done
);
    reg  [15:0] cnt_r;
    reg         busy_r;
    wire [15:0] atomic_ticks = `EEPC_ATOMIC_TICKS;
    wire [15:0] split_ticks  = `EEPC_SPLIT_TICKS;

    // no reset: a running program cycle finishes through reset
    initial begin
        busy_r = 1'b0;
        cnt_r  = 16'h0000;
    end

    always @(posedge i_clk) begin
        if (i_start && !busy_r) begin
            busy_r <= 1'b1;
            cnt_r  <= i_long ? atomic_ticks : split_ticks;
        end else if (busy_r && i_osc_tick) begin
            if (cnt_r == 16'h0001) begin
                busy_r <= 1'b0;
            end
            cnt_r <= cnt_r - 16'h0001;
        end
    end

    assign o_busy = busy_r;
    assign o_done = busy_r && i_osc_tick && (cnt_r == 16'h0001);
endmodule

// ### design/eepc_ctrl.v
`timescale 1ns/1ns
`include "eepc_defines.vh"
// Summary of operation
// - mode 00 armed strobe starts erase+write
// - strobe reads one until atomic done
// - busy blocks read, erase, write
// - mode 01 erases byte only
// - erase-only strobe held, hardware clears
// - mode 10 writes without erase
// - duration timed by calibrated oscillator
// - reset never aborts running program
// - low i/o space bit set/clear/test
// - i/o registers mirrored at +0x20
// - high address register reads zero
// - low address selects 256 bytes linearly
// - arm self-clears after four cycles
// - 3.4 ms atomic, 1.8 ms split
// - mode locked while busy, reset zeroes only when idle
// - ready interrupt level while idle
module eepc_ctrl (
    input  wire        i_clk,
    input  wire        i_srst,
    input  wire        i_osc_tick,
    input  wire        i_io_wr,
    input  wire        i_io_rd,
    input  wire        i_ds_sel,
    input  wire [7:0]  i_io_addr,
    input  wire [7:0]  i_io_wdata,
    input  wire        i_bit_set,
    input  wire        i_bit_clr,
    input  wire [2:0]  i_bit_num,
    output reg  [7:0]  o_io_rdata,
    output wire        o_bit_test,
    output wire        o_irq
);
    // ============================================================
    // storage and state
    reg  [7:0]  mem_r [0:255];
    reg  [7:0]  addr_low_reg_r;
    reg  [7:0]  byte_data_reg_r;
    // control register fields kept as separate flops
    reg  [1:0]  prog_mode_sel_r;
    reg         ready_irq_enable_r;
    reg         program_arm_r;
    reg  [2:0]  arm_cnt_r;
    // copy of the operation in flight, taken when the strobe is accepted
    reg  [1:0]  act_mode_r;
    reg  [7:0]  act_addr_r;
    reg  [7:0]  act_data_r;
    // timer handshake
    wire        busy;
    wire        done;
    integer     fill_idx;

    // ============================================================
    // address decode
    wire [7:0]  io_off   = i_ds_sel ? (i_io_addr - `EEPC_DS_OFFSET) : i_io_addr;
    // the data-space alias window sits one offset above the i/o window
    wire        ds_hit   = (i_io_addr >= `EEPC_DS_OFFSET) && (i_io_addr <= (`EEPC_IO_LAST + `EEPC_DS_OFFSET));
    wire        io_hit   = (i_io_addr <= `EEPC_IO_LAST);
    wire        in_range = i_ds_sel ? ds_hit : io_hit;
    wire        bit_ok   = !i_ds_sel && (i_io_addr <= {2'b00, `EEPC_BIT_IO_LAST});
    wire        bit_op   = (i_bit_set || i_bit_clr) && bit_ok;
    wire        wr_any   = (i_io_wr || bit_op) && in_range;
    wire        sel_cr   = wr_any && io_off == {2'b00, `EEPC_IO_CTRL};
    wire        sel_dr   = wr_any && io_off == {2'b00, `EEPC_IO_DATA};
    wire        sel_al   = wr_any && io_off == {2'b00, `EEPC_IO_ADDR_LO};
    wire [7:0]  cr_view;
    reg  [7:0]  cur_val;
    reg  [7:0]  wval;

    // ============================================================
    // register read view; unmapped bytes, the high address byte included, read zero
    assign cr_view = {2'b00, prog_mode_sel_r, ready_irq_enable_r, program_arm_r, busy, 1'b0};

    always @* begin
        case (io_off)
            {2'b00, `EEPC_IO_CTRL}:    cur_val = cr_view;
            {2'b00, `EEPC_IO_DATA}:    cur_val = byte_data_reg_r;
            {2'b00, `EEPC_IO_ADDR_LO}: cur_val = addr_low_reg_r;
            default:                   cur_val = 8'h00;
        endcase
    end

    // single-bit ops touch only the addressed bit
    always @* begin
        if (bit_op) begin
            wval = cur_val;
            wval[i_bit_num] = i_bit_set;
        end else begin
            wval = i_io_wdata;
        end
    end

    // ============================================================
    // strobe decode
    // strobes only fire on a written one; a bit op counts only for its own bit,
    // so setting the enable bit never re-fires a strobe that reads back as one
    wire [7:0]  bit_mask = 8'h01 << i_bit_num;
    wire [7:0]  wr_ones  = (bit_op ? bit_mask : 8'hFF) & wval & {8{sel_cr}};
    wire        wr_read  = wr_ones[`EEPC_CR_READ];
    wire        wr_prog  = wr_ones[`EEPC_CR_PROG];
    wire        wr_arm   = wr_ones[`EEPC_CR_ARM];
    wire        arm_last = (arm_cnt_r == 3'h1);
    wire        mode_ok  = (prog_mode_sel_r != `EEPC_MODE_RSVD);
    wire        long_op  = (prog_mode_sel_r == `EEPC_MODE_ATOMIC);
    wire        start    = wr_prog && program_arm_r && !busy && mode_ok;

    // ============================================================
    // control register
    // enable and arm clear on reset; the mode field is kept while a cycle runs
    always @(posedge i_clk) begin
        if (i_srst) begin
            ready_irq_enable_r <= 1'b0;
            program_arm_r      <= 1'b0;
            arm_cnt_r          <= 3'h0;
            if (!busy) begin
                prog_mode_sel_r <= `EEPC_MODE_ATOMIC;
            end
        end else begin
            if (sel_cr) begin
                ready_irq_enable_r <= wval[`EEPC_CR_RIE];
                if (!busy) begin
                    prog_mode_sel_r <= wval[`EEPC_CR_MODE_HI:`EEPC_CR_MODE_LO];
                end
            end
            // a new arm write wins over expiry and acceptance, so it always restarts the window
            if (wr_arm) begin
                program_arm_r <= 1'b1;
                arm_cnt_r     <= `EEPC_ARM_CYCLES;
            end else if (start) begin
                program_arm_r <= 1'b0;
                arm_cnt_r     <= 3'h0;
            end else if (arm_cnt_r != 3'h0) begin
                arm_cnt_r <= arm_cnt_r - 3'h1;
                if (arm_last) begin
                    program_arm_r <= 1'b0;
                end
            end
        end
    end

    // ============================================================
    // address and data; the address stays frozen during programming
    // the address has no reset value: it keeps whatever was last loaded
    always @(posedge i_clk) begin
        if (!i_srst && sel_al && !busy) begin
            addr_low_reg_r <= wval;
        end
    end

    // the read strobe loads the data register at once; while busy the old byte stays
    always @(posedge i_clk) begin
        if (i_srst) begin
            byte_data_reg_r <= `EEPC_DR_RESET;
        end else if (wr_read && !busy) begin
            byte_data_reg_r <= mem_r[addr_low_reg_r];
        end else if (sel_dr) begin
            byte_data_reg_r <= wval;
        end
    end

    // ============================================================
    // array and program sequencing; deliberately ignores reset
    // a fresh array reads as erased, so write-only mode works on untouched bytes
    initial begin
        for (fill_idx = 0; fill_idx < 256; fill_idx = fill_idx + 1) begin
            mem_r[fill_idx] = 8'hFF;
        end
    end

    always @(posedge i_clk) begin
        if (start) begin
            act_mode_r <= prog_mode_sel_r;
            act_addr_r <= addr_low_reg_r;
            act_data_r <= byte_data_reg_r;
        end
        if (done) begin
            // write-only can only clear bits; an unerased byte ends up as the and of both
            case (act_mode_r)
                `EEPC_MODE_ATOMIC: mem_r[act_addr_r] <= act_data_r;
                `EEPC_MODE_ERASE:  mem_r[act_addr_r] <= 8'hFF;
                `EEPC_MODE_WRITE:  mem_r[act_addr_r] <= mem_r[act_addr_r] & act_data_r;
                default:           mem_r[act_addr_r] <= mem_r[act_addr_r];
            endcase
        end
    end

    // duration follows the mode at acceptance; the mode is locked from then on
    eepc_prog_timer u_timer (
        .i_clk      (i_clk),
        .i_start    (start),
        .i_long     (long_op),
        .i_osc_tick (i_osc_tick),
        .o_busy     (busy),
        .o_done     (done)
    );

    // ============================================================
    // read port
    // idle cycles return zero so the read bus can be or-ed with other sources
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_io_rdata <= 8'h00;
        end else if (i_io_rd && in_range) begin
            o_io_rdata <= cur_val;
        end else begin
            o_io_rdata <= 8'h00;
        end
    end

    // ============================================================
    // status outputs
    assign o_bit_test = bit_ok && cur_val[i_bit_num];
    assign o_irq      = ready_irq_enable_r && !busy;
endmodule

// ### verif/eepc_ctrl_monitor.sv
`timescale 1ns/1ns
// ============================================================
// port checks of the nv access controller
module eepc_ctrl_monitor (
    input wire       i_clk,
    input wire       i_srst,
    input wire       i_io_wr,
    input wire       i_io_rd,
    input wire       i_ds_sel,
    input wire [7:0] i_io_addr,
    input wire       i_bit_set,
    input wire       i_bit_clr,
    input wire [2:0] i_bit_num,
    input wire [7:0] o_io_rdata,
    input wire       o_bit_test,
    input wire       o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    wire on_ctl = !i_ds_sel && i_io_addr == 8'h1C;
    wire b1 = on_ctl && i_bit_num == 3'h1, b3 = on_ctl && i_bit_num == 3'h3;
    wire at_hi = i_io_addr == {2'h0, i_ds_sel, 5'h1F}, at_ctl = i_io_addr == {2'h0, i_ds_sel, 5'h1C};
    a_rd_idle_zero: assert property (!i_io_rd |=> o_io_rdata == 8'h00) else $error("stray rdata");
    a_high_addr_zero: assert property (i_io_rd && at_hi |=> o_io_rdata == 8'h00) else $error("hi addr");
    a_ctl_spare_zero: assert property (i_io_rd && at_ctl |=> (o_io_rdata & 8'hC1) == 8'h00) else $error("spare");
    a_test_in_range: assert property (i_io_addr > 8'h1F |-> !o_bit_test) else $error("bit range");
    a_set_one_bit: assert property (i_bit_set && b3 ##1 b3 |-> o_bit_test) else $error("bit set");
    a_irq_needs_en: assert property (b3 && !o_bit_test |-> !o_irq) else $error("irq no enable");
    a_busy_no_irq: assert property (b1 && o_bit_test |-> !o_irq) else $error("irq busy");
    a_irq_fall_cause: assert property ($fell(o_irq) |->
        $past(i_io_wr) || $past(i_bit_set) || $past(i_bit_clr) || $past(i_srst))
        else $error("irq fell");
    cover property (b1 && o_bit_test);
    cover property ($rose(o_irq));
    cover property (i_bit_clr && b3);
endmodule
bind eepc_ctrl eepc_ctrl_monitor u_eepc_ctrl_monitor (
    .i_clk      (i_clk),
    .i_srst     (i_srst),
    .i_io_wr    (i_io_wr),
    .i_io_rd    (i_io_rd),
    .i_ds_sel   (i_ds_sel),
    .i_io_addr  (i_io_addr),
    .i_bit_set  (i_bit_set),
    .i_bit_clr  (i_bit_clr),
    .i_bit_num  (i_bit_num),
    .o_io_rdata (o_io_rdata),
    .o_bit_test (o_bit_test),
    .o_irq      (o_irq)
);

// ### verif/eepc_cpu.sv
`timescale 1ns/1ns
// ============================================================
// cpu side: one request at a time, launched on the falling edge
module eepc_cpu (
    input  wire        i_clk,
    input  wire  [7:0] i_rdata,
    output logic       o_wr,
    output logic       o_rd,
    output logic       o_ds,
    output logic       o_set,
    output logic       o_clr,
    output logic [2:0] o_bnum,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    initial {o_wr, o_rd, o_ds, o_set, o_clr, o_bnum, o_addr, o_wdata} = 24'h000000;
    // k: 0 write, 1 read, 2 bit set, 3 bit clear; address bit 5 picks the data-space alias
    task automatic req(input logic [1:0] k, input logic [7:0] a, d, output logic [7:0] q);
        @(negedge i_clk);
        {o_ds, o_addr, o_wdata, o_bnum} = {a[5], a, d, d[2:0]};
        {o_wr, o_rd, o_set, o_clr} = 4'h8 >> k;
        @(negedge i_clk);
        {o_wr, o_rd, o_set, o_clr} = 4'h0;
        q = i_rdata;
    endtask
endmodule

// ### verif/eeprom_program_read_ctrl_tb.sv
`timescale 1ns/1ns
// ============================================================
// bench
module eeprom_program_read_ctrl_tb;
    logic        clk = 1'b0, srst = 1'b1, tick_en = 1'b0;
    logic  [7:0] v;
    wire         wr, rd, ds, bset, bclr, btest, irq;
    wire   [7:0] addr, wdata, rdata;
    wire   [2:0] bnum;
    int          num_errors = 0, comparisons = 0, tk = 0, t0 = 0;
    logic [23:0] rows [4] = '{24'h1E5A5A, 24'h3EA5A5, 24'h1DC3C3, 24'h3F0100};
    always #50 clk = ~clk;
    always @(posedge clk) if (tick_en) tk <= tk + 1;
    eepc_cpu u_eepc_cpu (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_ds(ds), .o_set(bset),
        .o_clr(bclr), .o_bnum(bnum), .o_addr(addr), .o_wdata(wdata));
    eepc_ctrl u_eepc_ctrl (.i_clk(clk), .i_srst(srst), .i_osc_tick(tick_en), .i_io_wr(wr), .i_io_rd(rd),
        .i_ds_sel(ds), .i_io_addr(addr), .i_io_wdata(wdata), .i_bit_set(bset), .i_bit_clr(bclr),
        .i_bit_num(bnum), .o_io_rdata(rdata), .o_bit_test(btest), .o_irq(irq));
    task automatic io(input logic [1:0] k, input logic [7:0] a, d);
        u_eepc_cpu.req(k, a, d, v);
    endtask
    task automatic chk(input logic [7:0] g, e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [7:0] a, m, e);
        io(2'h1, a, 8'h00);
        chk(v & m, e);
    endtask
    // byte 0x10 only; t0 marks the start so the timing window counts oscillator ticks
    task automatic prog(input logic [7:0] c, d);
        io(2'h0, 8'h1C, c);
        io(2'h0, 8'h1E, 8'h10);
        io(2'h0, 8'h1D, d);
        io(2'h2, 8'h1C, 8'h02);
        io(2'h2, 8'h1C, 8'h01);
        t0 = tk;
    endtask
    task automatic done(input int n, input logic [7:0] e);
        wait (tk - t0 >= n - 20);
        rdc(8'h1C, 8'h02, 8'h02);
        wait (tk - t0 >= n + 20);
        rdc(8'h1C, 8'h02, 8'h00);
        io(2'h0, 8'h1C, 8'h01);
        rdc(8'h1D, 8'hFF, e);
    endtask
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        srst = 1'b0;
        foreach (rows[i]) begin
            io(2'h0, rows[i][23:16], rows[i][15:8]);
            rdc(rows[i][23:16] ^ 8'h20, 8'hFF, rows[i][7:0]);
        end
        tick_en = 1'b1;
        prog(8'h08, 8'hA5);
        chk({6'h00, btest, irq}, 8'h02);
        tick_en = 1'b0;
        repeat (200) @(negedge clk);
        tick_en = 1'b1;
        done(27200, 8'hA5);
        prog(8'h10, 8'h00);
        srst = 1'b1;
        @(negedge clk) srst = 1'b0;
        io(2'h0, 8'h1C, 8'h29);
        io(2'h0, 8'h1E, 8'h77);
        rdc(8'h1C, 8'h32, 8'h12);
        rdc(8'h1E, 8'hFF, 8'h10);
        rdc(8'h1D, 8'hFF, 8'h00);
        done(14400, 8'hFF);
        prog(8'h20, 8'h3C);
        done(14400, 8'h3C);
        io(2'h0, 8'h1C, 8'h30);
        io(2'h2, 8'h1C, 8'h02);
        io(2'h2, 8'h1C, 8'h01);
        rdc(8'h1C, 8'h02, 8'h00);
        io(2'h0, 8'h1C, 8'h04);
        repeat (4) @(negedge clk);
        io(2'h2, 8'h1C, 8'h01);
        rdc(8'h1C, 8'h06, 8'h00);
        io(2'h2, 8'h1C, 8'h03);
        chk({7'h00, irq}, 8'h01);
        io(2'h3, 8'h1C, 8'h03);
        chk({7'h00, irq}, 8'h00);
        wrap_up();
    end
    initial begin
        repeat (80000) @(negedge clk);
        num_errors++;
        wrap_up();
    end
endmodule
